// >>> shared/dpt_core_if.sv
/*
  carrier between the timer's own modules: synchronised pin edges and the
  commands and values of the counter/reload storage.
  assumes all three modules run on the same clock.
*/
`timescale 1ns/1ps
interface dpt_core_if;
  import dpt_pkg::*;
  logic [1:0] rise;                 // qualified rising edge, [0]=a, [1]=b
  logic [1:0] fall;                 // qualified falling edge
  logic load;                       // load counter from load_val
  logic dec;                        // count down by one, wraps at zero
  logic [DPT_CNT_W-1:0] load_val;
  logic cap_a;                      // copy count into reload_capture_a
  logic cap_b;                      // copy count into reload_capture_b
  logic wr_a;                       // software write of reload_capture_a
  logic wr_b;                       // software write of reload_capture_b
  logic [DPT_CNT_W-1:0] wr_val;
  logic [DPT_CNT_W-1:0] count;
  logic [DPT_CNT_W-1:0] ra;
  logic [DPT_CNT_W-1:0] rb;

  modport sync (output rise, fall);
  modport data (input load, dec, load_val, cap_a, cap_b, wr_a, wr_b,
    wr_val, output count, ra, rb);
  modport ctrl (input rise, fall, count, ra, rb, output load, dec,
    load_val, cap_a, cap_b, wr_a, wr_b, wr_val);
endinterface : dpt_core_if

// >>> shared/dpt_pkg.sv
/*
  constants shared by the dual reload pwm/capture timer: register offsets,
  field positions, reset values and the operating mode enumeration.
  assumes a 12-bit apb byte address and 32-bit apb data.
*/
package dpt_pkg;

  // counter and register width
  localparam int DPT_CNT_W = 16;
  localparam int DPT_ADDR_W = 12;

  // register byte offsets, one aligned word each
  localparam logic [11:0] DPT_OFS_CTRL = 12'h000; // mode and run bits
  localparam logic [11:0] DPT_OFS_STAT = 12'h004; // pending and enables
  localparam logic [11:0] DPT_OFS_CNT = 12'h008;  // main_timer count
  localparam logic [11:0] DPT_OFS_RCA = 12'h00C;  // reload_capture_a
  localparam logic [11:0] DPT_OFS_RCB = 12'h010;  // reload_capture_b

  // control register: four upper bits of the low byte
  localparam int DPT_CTRL_LSB = 4;
  localparam int DPT_BIT_RUN = 4; // run_or_underflow_flag
  localparam int DPT_BIT_LO = 5;  // mode_select_lo
  localparam int DPT_BIT_MID = 6; // mode_select_mid
  localparam int DPT_BIT_HI = 7;  // mode_select_hi

  // status register fields
  localparam int DPT_BIT_PEND_A = 0; // pending_a
  localparam int DPT_BIT_EN_A = 1;   // irq_enable_a
  localparam int DPT_BIT_PEND_B = 2; // pending_b
  localparam int DPT_BIT_EN_B = 3;   // irq_enable_b

  // reset values of control state
  localparam logic [3:0] DPT_CTRL_RST = 4'h0;
  localparam logic [3:0] DPT_STAT_RST = 4'h0;

  // operating modes decoded from hi, mid, lo
  typedef enum logic [1:0] {
    DPT_MODE_EVENT,
    DPT_MODE_PWM,
    DPT_MODE_CAPTURE
  } dpt_mode_e;

endpackage : dpt_pkg

// >>> testbench/dpt_pin_model.sv
/*
  signal sources wired to the two timer pins.
  assumes the bench calls put_a/put_b just after a rising clock edge.
*/
`timescale 1ns/1ps
module dpt_pin_model
(
  input wire logic pin_a_oe,
  input wire logic pin_a_out,
  output logic pin_a,
  output logic pin_b
);
  logic drv_a = 1'b0; // level our source puts on pin a
  logic drv_b = 1'b0; // level on pin b
  // pin a wire: the timer wins while it drives, else our source
  assign pin_a = pin_a_oe ? pin_a_out : drv_a;
  assign pin_b = drv_b;
  // levels change by nba so the timer samples them a clean cycle later
  task put_a(input logic v);
    drv_a <= v;
  endtask : put_a
  task put_b(input logic v);
    drv_b <= v;
  endtask : put_b
endmodule : dpt_pin_model

// >>> testbench/dpt_timer_assertions.sv
/*
  checker for the timer: apb answer, pin a drive, interrupt gating.
  assumes it is bound into dpt_timer and sees only its ports.
*/
`timescale 1ns/1ps
module dpt_timer_chk
  import dpt_pkg::*;
(
  input logic CLK,
  input logic RSTN,
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [11:0] PADDR,
  input logic [31:0] PWDATA,
  input logic [31:0] PRDATA,
  input logic PREADY,
  input logic PSLVERR,
  input logic TIMER_PIN_A_IN,
  input logic TIMER_PIN_A_OUT,
  input logic TIMER_PIN_A_OE,
  input logic TIMER_PIN_B_IN,
  input logic IRQ_A,
  input logic IRQ_B
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic wacc; // write taken at this edge
  logic [2:0] mode_q; // hi, mid, lo as software last wrote them
  logic en_a_q; // irq_enable_a shadow
  logic en_b_q; // irq_enable_b shadow
  logic sw_q; // ctrl or stat written at the last edge
  assign wacc = PSEL && PENABLE && PREADY && PWRITE;
  // shadows move on the write edge, in step with the design's copies
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mode_q <= 3'h0;
      en_a_q <= 1'b0;
      en_b_q <= 1'b0;
      sw_q <= 1'b0;
    end
    else
    begin
      sw_q <= wacc && (PADDR == DPT_OFS_CTRL || PADDR == DPT_OFS_STAT);
      if (wacc && PADDR == DPT_OFS_CTRL)
        mode_q <= PWDATA[DPT_BIT_HI:DPT_BIT_LO];
      if (wacc && PADDR == DPT_OFS_STAT)
      begin
        en_a_q <= PWDATA[DPT_BIT_EN_A];
        en_b_q <= PWDATA[DPT_BIT_EN_B];
      end
    end
  end
  AST_READY_NEXT: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no answer one cycle after setup");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready held beyond one cycle");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY && PSEL)
    else $error("error flag outside access phase");
  AST_RDATA_IDLE: assert property (!(PREADY && !PWRITE) |-> PRDATA == 0)
    else $error("read data not zero outside a read");
  AST_IRQA_GATE: assert property (IRQ_A |-> en_a_q || $past(en_a_q))
    else $error("irq a without its enable");
  AST_IRQB_GATE: assert property (IRQ_B |-> en_b_q || $past(en_b_q))
    else $error("irq b without its enable");
  AST_OE_MODE: assert property (TIMER_PIN_A_OE |->
    mode_q == 3'h5 || $past(mode_q) == 3'h5)
    else $error("pin a driven outside toggle mode");
  AST_IRQ_HOLD: assert property ($fell(IRQ_A) |-> sw_q || $past(sw_q))
    else $error("irq a dropped without software write");
  AST_EVT_B: assert property ($rose(TIMER_PIN_B_IN) &&
    mode_q[2:1] == 2'h0 && en_b_q |-> ##[2:8] IRQ_B)
    else $error("event mode pin b rise not flagged");
  AST_CAP_A: assert property ($rose(TIMER_PIN_A_IN) &&
    mode_q == 3'h2 && en_a_q |-> ##[2:8] IRQ_A)
    else $error("capture a rise not flagged");
  AST_CAP_B: assert property ($fell(TIMER_PIN_B_IN) &&
    mode_q == 3'h6 && en_b_q |-> ##[2:8] IRQ_B)
    else $error("capture b fall not flagged");
  // main scenarios reached
  cover property (TIMER_PIN_A_OE && $changed(TIMER_PIN_A_OUT));
  cover property (IRQ_B && mode_q == 3'h0);
  cover property ($rose(IRQ_A) && mode_q[1]);
endmodule : dpt_timer_chk
bind dpt_timer dpt_timer_chk u_dpt_timer_chk (.CLK(CLK), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER_PIN_A_IN(TIMER_PIN_A_IN), .TIMER_PIN_A_OUT(TIMER_PIN_A_OUT),
  .TIMER_PIN_A_OE(TIMER_PIN_A_OE), .TIMER_PIN_B_IN(TIMER_PIN_B_IN),
  .IRQ_A(IRQ_A), .IRQ_B(IRQ_B));

// >>> testbench/testbench.sv
/*
  self-checking bench: apb tasks, pwm, event and capture sequences.
  assumes one clock at 250 MHz and the pin model beside the timer.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import dpt_pkg::*;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pa_out, pa_oe, pa_in, pb_in, irq_a, irq_b;
  logic [15:0] c1;
  logic [7:0] cm [4] = '{8'h40, 8'hC0, 8'h60, 8'hE0}; // capture codes
  logic [1:0] lv [4] = '{2'h0, 2'h1, 2'h3, 2'h3}; // start {a,b}
  int error_cnt, checks, n;
  dpt_timer u_dpt_timer (.CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TIMER_PIN_A_IN(pa_in), .TIMER_PIN_A_OUT(pa_out),
    .TIMER_PIN_A_OE(pa_oe), .TIMER_PIN_B_IN(pb_in), .IRQ_A(irq_a),
    .IRQ_B(irq_b));
  dpt_pin_model u_dpt_pin_model (.pin_a_oe(pa_oe), .pin_a_out(pa_out),
    .pin_a(pa_in), .pin_b(pb_in));
  // free running 4 ns clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // one apb transfer, entered just after an edge; bounded ready wait
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      error_cnt++;
      end_of_test();
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, e, rv)
  endtask : rdc
  // cycles until pin a output changes, capped
  task automatic tog(output int m);
    logic p;
    p = pa_out;
    m = 0;
    do
    begin
      @(posedge clk);
      m++;
    end
    while (pa_out === p && m < 100);
  endtask : tog
  task pulse_a;
    u_dpt_pin_model.put_a(1'b1);
    tick(8);
    u_dpt_pin_model.put_a(1'b0);
    tick(8);
  endtask : pulse_a
  task end_of_test;
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    error_cnt = 0;
    checks = 0;
    tick(5);
    rstn <= 1'b1;
    tick(1);
    rdc(DPT_OFS_STAT, 32'h0, "stat_rst");
    wr(DPT_OFS_CTRL, 32'hFFFF_FF0F);
    rdc(DPT_OFS_CTRL, 32'h0, "ctrl_low_bits");
    wr(12'h014, 32'hFFFF_FFFF);
    rdc(12'h014, 32'h0, "unmapped");
    `CHK("unmapped_err", 1'b1, err)
    // pwm with toggle: phases are reload plus one clocks
    wr(DPT_OFS_RCA, 32'h0000_0005);
    wr(DPT_OFS_RCB, 32'h0000_0009);
    wr(DPT_OFS_CNT, 32'h0000_0003);
    wr(DPT_OFS_STAT, 32'h0000_0002);
    wr(DPT_OFS_CTRL, 32'h0000_00B0);
    tog(n);
    tog(n);
    `CHK("phase_a", 8'h06, n)
    tog(n);
    `CHK("phase_b", 8'h0A, n)
    `CHK("oe_pwm", 1'b1, pa_oe)
    rdc(DPT_OFS_STAT, 32'h0000_0007, "pwm_pend");
    `CHK("irq_a_en", 1'b1, irq_a)
    `CHK("irq_b_dis", 1'b0, irq_b)
    wr(DPT_OFS_STAT, 32'h0000_0008);
    tick(20);
    `CHK("irq_a_off", 1'b0, irq_a)
    `CHK("irq_b_on", 1'b1, irq_b)
    wr(DPT_OFS_CTRL, 32'h0000_00A0);
    rdc(DPT_OFS_STAT, 32'h0000_000D, "pend_hold");
    xfer(1'b0, DPT_OFS_CNT, 32'h0);
    rdc(DPT_OFS_CNT, rv, "pwm_stopped");
    wr(DPT_OFS_CTRL, 32'h0000_0090);
    tick(20);
    `CHK("oe_no_toggle", 1'b0, pa_oe)
    // event counter, rising then falling pin a edges
    wr(DPT_OFS_CTRL, 32'h0);
    wr(DPT_OFS_CNT, 32'h0000_0002);
    wr(DPT_OFS_STAT, 32'h0000_000A);
    wr(DPT_OFS_CTRL, 32'h0000_0010);
    repeat (3) pulse_a();
    rdc(DPT_OFS_CNT, 32'h0000_FFFF, "evt_wrap");
    rdc(DPT_OFS_STAT, 32'h0000_000B, "evt_unf");
    u_dpt_pin_model.put_b(1'b1);
    tick(8);
    u_dpt_pin_model.put_b(1'b0);
    rdc(DPT_OFS_STAT, 32'h0000_000F, "evt_pin_b");
    `CHK("oe_event", 1'b0, pa_oe)
    wr(DPT_OFS_CTRL, 32'h0000_0030);
    wr(DPT_OFS_CNT, 32'h0000_0005);
    u_dpt_pin_model.put_a(1'b1);
    tick(8);
    rdc(DPT_OFS_CNT, 32'h0000_0005, "evt_rise_skip");
    u_dpt_pin_model.put_a(1'b0);
    tick(8);
    rdc(DPT_OFS_CNT, 32'h0000_0004, "evt_fall");
    wr(DPT_OFS_CTRL, 32'h0000_0020);
    pulse_a();
    rdc(DPT_OFS_CNT, 32'h0000_0004, "evt_stopped");
    // capture: every edge code, a then b a known gap apart
    wr(DPT_OFS_CTRL, 32'h0);
    wr(DPT_OFS_CNT, 32'h0000_8000);
    for (int i = 0; i < 4; i++)
    begin
      u_dpt_pin_model.put_a(lv[i][1]);
      u_dpt_pin_model.put_b(lv[i][0]);
      tick(8);
      wr(DPT_OFS_CTRL, {24'h0, cm[i]});
      wr(DPT_OFS_STAT, 32'h0000_000A);
      u_dpt_pin_model.put_a(!lv[i][1]);
      tick(10 + 3 * i);
      u_dpt_pin_model.put_b(!lv[i][0]);
      tick(8);
      xfer(1'b0, DPT_OFS_RCA, 32'h0);
      c1 = rv[15:0];
      xfer(1'b0, DPT_OFS_RCB, 32'h0);
      c1 = c1 - rv[15:0];
      `CHK("cap_gap", 16'(10 + 3 * i), c1)
      rdc(DPT_OFS_STAT, 32'h0000_000F, "cap_pend");
    end
    xfer(1'b0, DPT_OFS_CNT, 32'h0);
    c1 = rv[15:0];
    xfer(1'b0, DPT_OFS_RCA, 32'h0);
    xfer(1'b0, DPT_OFS_CNT, 32'h0);
    c1 = c1 - rv[15:0];
    `CHK("cnt_running", 16'h0006, c1)
    wr(DPT_OFS_STAT, 32'h0000_0002);
    wr(DPT_OFS_CNT, 32'h0000_0003);
    tick(10);
    rdc(DPT_OFS_CTRL, 32'h0000_00F0, "cap_unf");
    `CHK("irq_a_unf", 1'b1, irq_a)
    wr(DPT_OFS_CTRL, 32'h0000_00E0);
    tick(2);
    `CHK("irq_a_clear", 1'b0, irq_a)
    end_of_test();
  end
endmodule : testbench

// >>> verilog/dpt_data.sv
/*
  counter and the two reload/capture registers.
  assumes the controller never asks for load and dec in a way it does not
  mean: load beats dec, capture beats a software write.
  these registers have no reset: their content starts undefined.
*/
`timescale 1ns/1ps
module dpt_data
  import dpt_pkg::*;
(
  input wire logic clk,
  dpt_core_if.data core
);

  typedef struct packed {
    logic [DPT_CNT_W-1:0] cnt; // main_timer
    logic [DPT_CNT_W-1:0] ra;  // reload_capture_a
    logic [DPT_CNT_W-1:0] rb;  // reload_capture_b
  } dpt_data_s;

  dpt_data_s st_reg;
  dpt_data_s st_next;

  assign core.count = st_reg.cnt;
  assign core.ra = st_reg.ra;
  assign core.rb = st_reg.rb;

  // next values; a plain decrement wraps zero to all ones
  always_comb
  begin
    st_next = st_reg;
    if (core.load)
      st_next.cnt = core.load_val;
    else if (core.dec)
      st_next.cnt = st_reg.cnt - 16'h0001; // [R24]
    if (core.cap_a)
      st_next.ra = st_reg.cnt; // [R12]
    else if (core.wr_a)
      st_next.ra = core.wr_val;
    if (core.cap_b)
      st_next.rb = st_reg.cnt; // [R12]
    else if (core.wr_b)
      st_next.rb = core.wr_val;
  end

  // no reset on purpose: power-up content is undefined
  always_ff @(posedge clk)
  begin
    st_reg <= st_next; // [R22]
  end

endmodule : dpt_data

// >>> verilog/dpt_pin_sync.sv
/*
  three-stage synchroniser and edge qualifier for the two timer pins.
  assumes pins are asynchronous to clk; an edge is reported once the
  second and third stages agree on a new level.
*/
`timescale 1ns/1ps
module dpt_pin_sync
  import dpt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] pins,
  dpt_core_if.sync core
);

  typedef struct packed {
    logic [1:0] s0;   // first stage, read only by s1
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] lvl;  // accepted level
    logic [2:0] fill; // stages already holding a real pin sample
    logic primed;     // lvl holds a real pin level
  } dpt_sync_s;

  dpt_sync_s st_reg;
  dpt_sync_s st_next;
  logic [1:0] agree;

  // stages agree: the change is accepted
  assign agree = ~(st_reg.s1 ^ st_reg.s2);

  // edges per pin; none until every stage holds a real pin sample, so a
  // pin that idles high gives no false edge after reset
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_edge
      assign core.rise[gi] = st_reg.primed & agree[gi] & st_reg.s2[gi] &
        ~st_reg.lvl[gi]; // [R25]
      assign core.fall[gi] = st_reg.primed & agree[gi] & ~st_reg.s2[gi] &
        st_reg.lvl[gi]; // [R25]
    end
  endgenerate

  // shift chain and level update
  always_comb
  begin
    st_next = st_reg;
    st_next.s0 = pins;
    st_next.s1 = st_reg.s0;
    st_next.s2 = st_reg.s1;
    st_next.fill = {st_reg.fill[1:0], 1'b1};
    // until primed, follow the pin without reporting edges
    if (st_reg.primed)
      st_next.lvl = (agree & st_reg.s2) | (~agree & st_reg.lvl);
    else
      st_next.lvl = st_reg.s2;
    st_next.primed = st_reg.primed | st_reg.fill[2];
  end

  // state register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

endmodule : dpt_pin_sync

// >>> verilog/dpt_timer.sv
/*
  dual reload pwm / event counter / input capture timer with an apb slave.
  assumes an apb master on CLK; timer pins are asynchronous inputs and
  pin a is two-way (in, out, output enable). one count per CLK period.
*/
// The implementer's own choices: the register offsets and the APB register port.
// Functional notes
// (R01) pwm mode counts down every clock
// (R02) pwm reloads a first, then alternates b, a
// (R03) code 101 toggles pin a, 100 does not
// (R04) pwm reload from a/b sets pending a/b
// (R05) pending flags stay until software clears them
// (R06) interrupt only while matching enable is set
// (R07) event mode counts selected edges on pin a
// (R08) event mode underflow sets pending a
// (R09) event mode rising pin b sets pending b
// (R10) event mode never drives pin a
// (R11) capture mode counts every clock
// (R12) capture copies count on pin a/b trigger
// (R13) capture registers readable without disturbing count
// (R14) capture triggers set pending a/b
// (R15) capture underflow sets run flag, enabled by a
// (R16) software clears run flag entering capture mode
// (R17) software checks both flags on source a
// (R18) pwm/event modes run only while run flag set
// (R19) capture edge polarity follows mode code
// (R20) each capture pin has own trigger condition
// (R21) pwm reload at zero raises an interrupt event
// (R22) counter and reload registers not reset
// (R23) mode and run bits are control bits 7:4
// (R24) event/capture modes wrap zero to all ones
// (R25) pin edges synchronised, one event per edge
`timescale 1ns/1ps
module dpt_timer
  import dpt_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_PIN_A_IN,
  output logic TIMER_PIN_A_OUT,
  output logic TIMER_PIN_A_OE,
  input wire logic TIMER_PIN_B_IN,
  output logic IRQ_A,
  output logic IRQ_B
);

  // all control state of the timer; data registers live in dpt_data
  typedef struct packed {
    logic [3:0] ctrl;     // hi, mid, lo, run_or_underflow_flag
    logic pend_a;         // pending_a
    logic en_a;           // irq_enable_a
    logic pend_b;         // pending_b
    logic en_b;           // irq_enable_b
    logic sel_b;          // next pwm reload comes from reload_capture_b
    logic pin_out;        // pwm level on pin a
    logic pin_oe;         // pin a driven
    logic irq_a;          // source a request
    logic irq_b;          // source b request
    logic pready;         // apb ready, high in the access phase
    logic pslverr;        // apb error for unmapped address
    logic [31:0] prdata;  // apb read data, captured in setup phase
  } dpt_main_s;

  dpt_main_s st_reg;
  dpt_main_s st_next;

  dpt_core_if core ();

  // pin synchroniser and edge qualifier
  dpt_pin_sync u_sync (
    .clk (CLK),
    .rstn (RSTN),
    .pins ({TIMER_PIN_B_IN, TIMER_PIN_A_IN}),
    .core (core)
  );

  // counter and reload/capture storage
  dpt_data u_data (
    .clk (CLK),
    .core (core)
  );

  // register index decode, used by read and by write path
  function automatic logic [2:0] reg_index(input logic [11:0] addr);
    case (addr)
      DPT_OFS_CTRL: reg_index = 3'd1;
      DPT_OFS_STAT: reg_index = 3'd2;
      DPT_OFS_CNT: reg_index = 3'd3;
      DPT_OFS_RCA: reg_index = 3'd4;
      DPT_OFS_RCB: reg_index = 3'd5;
      default: reg_index = 3'd0; // unmapped
    endcase
  endfunction : reg_index

  // mode decode from hi, mid, lo
  function automatic dpt_mode_e mode_of(input logic [2:0] code);
    // mid wins over hi: every x1x code is a capture mode
    if (code[1])
      mode_of = DPT_MODE_CAPTURE;
    else if (code[2])
      mode_of = DPT_MODE_PWM;
    else
      mode_of = DPT_MODE_EVENT;
  endfunction : mode_of

  // decoded control fields
  dpt_mode_e mode;
  logic run;           // run_or_underflow_flag
  logic code_hi;
  logic code_lo;
  logic wr_acc;        // apb write taken at this edge
  logic setup;         // apb setup cycle
  logic [2:0] idx;     // decoded register index
  logic tick;          // counter steps this cycle
  logic uf;            // counter passes through zero this cycle
  logic ev_a;          // counting edge on pin a in event mode
  logic trig_a;        // capture trigger on pin a
  logic trig_b;        // capture trigger on pin b
  logic is_zero;

  // decode once from the registered control bits
  assign mode = mode_of(st_reg.ctrl[3:1]);
  assign run = st_reg.ctrl[0];
  assign code_hi = st_reg.ctrl[3];
  assign code_lo = st_reg.ctrl[1];
  assign idx = reg_index(PADDR);
  assign setup = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & st_reg.pready & PWRITE;
  assign is_zero = (core.count == 16'h0000);

  // edge polarity: lo selects the falling edge for the event counter
  assign ev_a = code_lo ? core.fall[0] : core.rise[0]; // [R07]
  // capture: a falls when lo, b falls when hi or lo
  assign trig_a = code_lo ? core.fall[0] : core.rise[0]; // [R19] [R20]
  assign trig_b = (code_hi | code_lo) ? core.fall[1]
    : core.rise[1]; // [R19] [R20]

  // counting source per mode
  always_comb
  begin
    case (mode)
      DPT_MODE_PWM: tick = run; // [R01] [R18]
      DPT_MODE_EVENT: tick = run & ev_a; // [R07] [R18]
      DPT_MODE_CAPTURE: tick = 1'b1; // [R11]
      default: tick = 1'b0;
    endcase
  end

  // zero seen while stepping: reload in pwm, wrap elsewhere
  assign uf = tick & is_zero;

  // next control state, storage commands and bus answers
  always_comb
  begin
    st_next = st_reg;
    core.load = 1'b0;
    core.dec = 1'b0;
    core.load_val = 16'h0000;
    core.cap_a = 1'b0;
    core.cap_b = 1'b0;
    core.wr_a = 1'b0;
    core.wr_b = 1'b0;
    core.wr_val = PWDATA[15:0];

    // software writes first, so that hardware sets below win
    if (wr_acc)
    begin
      case (idx)
        3'd1:
        begin
          // mode code and run flag; other bits are dropped
          st_next.ctrl = PWDATA[DPT_BIT_HI:DPT_CTRL_LSB]; // [R23]
        end
        3'd2:
        begin
          // pending bits cleared only here by software
          st_next.pend_a = PWDATA[DPT_BIT_PEND_A]; // [R05]
          st_next.en_a = PWDATA[DPT_BIT_EN_A];
          st_next.pend_b = PWDATA[DPT_BIT_PEND_B]; // [R05]
          st_next.en_b = PWDATA[DPT_BIT_EN_B];
        end
        3'd3:
        begin
          // count write; a pwm reload in this cycle overrides it
          core.load = 1'b1;
          core.load_val = PWDATA[15:0];
        end
        3'd4:
        begin
          // reload_capture_a; a capture in this cycle wins
          core.wr_a = 1'b1;
        end
        3'd5:
        begin
          // reload_capture_b; a capture in this cycle wins
          core.wr_b = 1'b1;
        end
        default:
        begin
          // unmapped write is dropped, error shown on pslverr
        end
      endcase
    end

    // mode specific counting, reload, capture and flags
    case (mode)
      DPT_MODE_PWM:
      begin
        if (uf)
        begin
          // reload at zero instead of wrapping
          core.load = 1'b1; // [R21]
          if (st_reg.sel_b)
          begin
            core.load_val = core.rb; // [R02]
            st_next.pend_b = 1'b1; // [R04] [R21]
          end
          else
          begin
            core.load_val = core.ra; // [R02]
            st_next.pend_a = 1'b1; // [R04] [R21]
          end
          st_next.sel_b = ~st_reg.sel_b; // [R02]
          if (code_lo)
            st_next.pin_out = ~st_reg.pin_out; // [R03]
        end
        else
        begin
          // no zero reached: plain step, or hold while stopped
          core.dec = tick; // [R01]
        end
        // only the toggle code drives the pin
        st_next.pin_oe = code_lo; // [R03]
      end
      DPT_MODE_EVENT:
      begin
        // count only qualified edges while running; wraps at zero
        core.dec = tick; // [R07] [R24]
        if (uf)
          st_next.pend_a = 1'b1; // [R08]
        // pin b is a free rising-edge flag input here
        if (core.rise[1])
          st_next.pend_b = 1'b1; // [R09]
        // pin a is the count input here
        st_next.pin_oe = 1'b0; // [R10]
        // a later pwm session starts from reload_capture_a again
        st_next.sel_b = 1'b0; // [R02]
      end
      DPT_MODE_CAPTURE:
      begin
        // free running; the run bit is not a stop control here
        core.dec = tick; // [R11] [R24]
        // capture beats a software write of the same register
        core.cap_a = trig_a; // [R12]
        core.cap_b = trig_b; // [R12]
        if (trig_a)
          st_next.pend_a = 1'b1; // [R14]
        if (trig_b)
          st_next.pend_b = 1'b1; // [R14]
        // run flag doubles as the underflow pending flag
        if (uf)
          st_next.ctrl[0] = 1'b1; // [R15]
        // capture inputs only; pin a is never driven
        st_next.pin_oe = 1'b0;
        st_next.sel_b = 1'b0; // [R02]
      end
      default:
      begin
        // unreachable decode; keep the pin released
        st_next.pin_oe = 1'b0;
      end
    endcase

    // requests follow the next flags, gated by each enable
    // registered so that the request lines are glitch free
    // capture mode also counts the run flag as a pending underflow
    if (mode_of(st_next.ctrl[3:1]) == DPT_MODE_CAPTURE)
      st_next.irq_a = st_next.en_a &
        (st_next.pend_a | st_next.ctrl[0]); // [R06] [R15]
    else
      st_next.irq_a = st_next.en_a & st_next.pend_a; // [R06] [R08]
    st_next.irq_b = st_next.en_b & st_next.pend_b; // [R06] [R09]

    // apb: answer prepared in the setup cycle, ready in access phase
    st_next.pready = setup;
    // an unmapped address still completes, with an error
    st_next.pslverr = setup & (idx == 3'd0);
    st_next.prdata = 32'h0000_0000;
    if (setup & ~PWRITE)
    begin
      // reads only sample; they never touch the running count
      case (idx)
        3'd1:
          st_next.prdata[DPT_BIT_HI:DPT_CTRL_LSB] = st_reg.ctrl; // [R23]
        3'd2:
        begin
          st_next.prdata[DPT_BIT_PEND_A] = st_reg.pend_a;
          st_next.prdata[DPT_BIT_EN_A] = st_reg.en_a;
          st_next.prdata[DPT_BIT_PEND_B] = st_reg.pend_b;
          st_next.prdata[DPT_BIT_EN_B] = st_reg.en_b;
        end
        3'd3: st_next.prdata[15:0] = core.count; // [R13]
        3'd4: st_next.prdata[15:0] = core.ra; // [R13]
        3'd5: st_next.prdata[15:0] = core.rb; // [R13]
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  // control state register; counter data is not reset here
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      // control and flags only; counter data has no reset
      st_reg <= '0;
      st_reg.ctrl <= DPT_CTRL_RST;
      st_reg.pend_a <= DPT_STAT_RST[DPT_BIT_PEND_A];
      st_reg.en_a <= DPT_STAT_RST[DPT_BIT_EN_A];
      st_reg.pend_b <= DPT_STAT_RST[DPT_BIT_PEND_B];
      st_reg.en_b <= DPT_STAT_RST[DPT_BIT_EN_B];
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign TIMER_PIN_A_OUT = st_reg.pin_out;
  assign TIMER_PIN_A_OE = st_reg.pin_oe;
  assign IRQ_A = st_reg.irq_a;
  assign IRQ_B = st_reg.irq_b;

endmodule : dpt_timer
